// *** rtl/sdc_pkg.sv ***
// Shared constants, types and register map of the segmented disk cache controller
package sdc_pkg;

  // ----------------------------------------------------------------
  // Buffer geometry
  // ----------------------------------------------------------------
  localparam int          BUF_KBYTES   = 4096;
  localparam int          SECTOR_BYTES = 512;
  localparam int          MAX_SEGS     = 32;
  localparam int          MIN_SEGS     = 1;
  localparam int          CYL_BITS     = 10;
  localparam logic [5:0]  SEGCNT_RST   = 6'h10;
  localparam logic [15:0] MAXPF_RST    = 16'h0100;
  localparam logic [15:0] PFCEIL_RST   = 16'hFFFF;
  localparam logic [7:0]  CTRL_RST     = 8'h00;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_SEGCNT  = 8'h04;
  localparam logic [7:0] OFS_PREFET  = 8'h08;
  localparam logic [7:0] OFS_SEGSIZE = 8'h0C;
  localparam logic [7:0] OFS_CMDLBA  = 8'h10;
  localparam logic [7:0] OFS_CMD     = 8'h14;
  localparam logic [7:0] OFS_STATUS  = 8'h18;
  localparam logic [7:0] OFS_HITS    = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_READ_CACHE_DIS = 0;
  localparam int BIT_REJECT_PARAMS  = 1;
  localparam int BIT_WRITE_BACK     = 2;
  localparam int BIT_CYL_CROSS      = 4;
  localparam int BIT_READAHEAD_DIS  = 5;
  localparam int BIT_INTERLEAVE     = 6;
  localparam int CMD_OP_LSB         = 16;
  localparam int ST_BUSY            = 0;
  localparam int ST_GOOD            = 1;
  localparam int ST_CMD_ERR         = 2;
  localparam int ST_DEFERRED        = 3;
  localparam int ST_PARAM_ERR       = 4;
  localparam int ST_PF_ON           = 5;
  localparam int ST_DIRTY           = 6;

  typedef enum logic [1:0] {
    SDC_OP_NONE  = 2'h0,
    SDC_OP_READ  = 2'h1,
    SDC_OP_WRITE = 2'h2,
    SDC_OP_SYNC  = 2'h3
  } sdc_op_e;

  typedef enum logic [2:0] {
    SDC_IDLE  = 3'h0,
    SDC_FLUSH = 3'h1,
    SDC_LOOK  = 3'h3,
    SDC_HIT   = 3'h2,
    SDC_FETCH = 3'h6,
    SDC_WRT   = 3'h7,
    SDC_MWAIT = 3'h5,
    SDC_DONE  = 3'h4
  } sdc_state_e;

  typedef struct packed {
    logic        wr;
    logic [31:0] lba;
    logic [15:0] cnt;
  } sdc_media_req_s;

  typedef struct packed {
    logic        from_cache;
    logic        paced;
    logic [31:0] lba;
    logic [15:0] cnt;
  } sdc_host_xfer_s;

endpackage

// *** rtl/sdc_cache_ctrl.sv ***
// Segmented disk cache directory, read look-ahead and write-back controller
//
// Summary of operation
// RULE_01: 4096 kbytes of buffer form the cache, split into logical segments.
// RULE_02: Any segment count 1 to 32 is accepted from the host.
// RULE_03: Each segment records the block addresses it currently holds.
// RULE_04: With read caching on, reads are served from buffer before medium.
// RULE_05: With read caching off, reads go to medium through a circular segment; code still serves prefetched blocks from buffer unless readahead is disabled.
// RULE_06: Misses follow buffer-full pacing; hits ignore it.
// RULE_07: Hit sends all contiguous cached blocks, then fetches the remainder.
// RULE_08: Miss fetches requested blocks into one segment, then forwards them.
// RULE_09: Segments wrap; length in sectors comes from segment count only.
// RULE_10: Segment size always reads back as zero.
// RULE_11: Host segment size ignored; flagged as unchangeable when reject_unchangeable_params checking set.
// RULE_12: Written data is retained for later read hits, same segmentation.
// RULE_13: Writes first clear every segment holding any target block.
// RULE_14: Write wrap never overwrites data not yet on the medium.
// RULE_15: Write-back gives early good status; later failure is a deferred error.
// RULE_16: Synchronize writes all cached write data before completing.
// RULE_17: Prefetch on when readahead not disabled, even without read caching.
// RULE_18: Maximum prefetch limits look-ahead; prefetch ceiling is ignored.
// RULE_19: Prefetch crosses a cylinder only when crossing is enabled.
// RULE_20: Without interleave, prefetch follows contiguity of consecutive reads.
// RULE_21: With interleave, prefetch follows a prediction of a likely hit.
// RULE_22: Caching and prefetch are independent controls.
// RULE_23: Hit test compares start block against every valid segment at once.
`timescale 1ns/1ps
`default_nettype none

module sdc_cache_ctrl #(
  parameter int NSEG     = sdc_pkg::MAX_SEGS,
  parameter int BUF_KB   = sdc_pkg::BUF_KBYTES,
  parameter int CYL_BITS = sdc_pkg::CYL_BITS
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    med_ack,
  input  wire logic                    med_err,
  output logic                         med_req_valid,
  output sdc_pkg::sdc_media_req_s      med_req,
  output logic                         host_xfer_valid,
  output sdc_pkg::sdc_host_xfer_s      host_xfer
);

  localparam int          SW       = $clog2(NSEG);
  localparam logic [15:0] TOT_SECT = 16'(BUF_KB * 1024 / sdc_pkg::SECTOR_BYTES); // [RULE_01]
  localparam logic [16:0] CYL_SIZE = 17'(2 ** CYL_BITS);

  // ----------------------------------------------------------------
  // Configuration and status state
  // ----------------------------------------------------------------
  logic [7:0]  ctrl;
  logic [5:0]  segcnt;
  logic [15:0] maxpf;
  logic [15:0] pfceil;
  logic [31:0] cmd_lba;
  logic        good;
  logic        cmd_err;
  logic        deferred;
  logic        param_err;
  logic [15:0] cache_hits;
  logic [15:0] pf_hits;

  logic read_cache_disable, reject_unchangeable_params, write_back_enable, cyl_cross, readahead_disable, interleave;
  assign read_cache_disable        = ctrl[sdc_pkg::BIT_READ_CACHE_DIS];
  assign reject_unchangeable_params     = ctrl[sdc_pkg::BIT_REJECT_PARAMS];
  assign write_back_enable        = ctrl[sdc_pkg::BIT_WRITE_BACK];
  assign cyl_cross  = ctrl[sdc_pkg::BIT_CYL_CROSS];
  assign readahead_disable        = ctrl[sdc_pkg::BIT_READAHEAD_DIS];
  assign interleave = ctrl[sdc_pkg::BIT_INTERLEAVE];

  // ----------------------------------------------------------------
  // Segment table and command context
  // ----------------------------------------------------------------
  logic [NSEG-1:0] seg_vld;
  logic [NSEG-1:0] seg_dirty;
  logic [31:0]     seg_lba [NSEG];
  logic [15:0]     seg_cnt [NSEG];
  logic [31:0]     seg_pfb [NSEG];

  sdc_pkg::sdc_state_e state;
  sdc_pkg::sdc_op_e    op;
  logic [31:0]         cur_lba;
  logic [15:0]         rem;
  logic [SW-1:0]       vic;
  logic [SW-1:0]       fl_idx;
  logic                fl_defer;
  logic                mw_flush;
  logic                wr_started;
  logic                pf_on;
  logic [31:0]         last_end;
  logic [15:0]         pf_amt_q;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic access, wr_fire, busy, any_dirty, bad_wr;
  assign access    = psel & penable & ~pready;
  assign wr_fire   = psel & penable & pready & pwrite & ~pslverr;
  assign busy      = (state != sdc_pkg::SDC_IDLE);
  assign any_dirty = |seg_dirty;

  logic cmd_go, seg_wr, stat_wr;
  assign cmd_go  = wr_fire & (paddr == sdc_pkg::OFS_CMD);
  assign seg_wr  = wr_fire & (paddr == sdc_pkg::OFS_SEGCNT);
  assign stat_wr = wr_fire & (paddr == sdc_pkg::OFS_STATUS);

  // Reconfiguring or starting while busy would corrupt the table
  always_comb begin
    bad_wr = 1'b0;
    if (pwrite && (paddr == sdc_pkg::OFS_CMD || paddr == sdc_pkg::OFS_SEGCNT)) begin
      bad_wr = busy | (paddr == sdc_pkg::OFS_SEGCNT && any_dirty);
    end
  end

  logic [31:0] rd_mux;
  logic        unmapped;
  always_comb begin
    rd_mux   = 32'h0000_0000;
    unmapped = 1'b0;
    unique case (paddr)
      sdc_pkg::OFS_CTRL:    rd_mux = {24'h00_0000, ctrl};
      sdc_pkg::OFS_SEGCNT:  rd_mux = {26'h000_0000, segcnt};
      sdc_pkg::OFS_PREFET:  rd_mux = {pfceil, maxpf};
      sdc_pkg::OFS_SEGSIZE: rd_mux = 32'h0000_0000; // [RULE_10]
      sdc_pkg::OFS_CMDLBA:  rd_mux = cmd_lba;
      sdc_pkg::OFS_CMD:     rd_mux = {14'h0000, op, rem};
      sdc_pkg::OFS_STATUS:  rd_mux = {25'h000_0000, any_dirty, pf_on, param_err, deferred, cmd_err, good, busy};
      sdc_pkg::OFS_HITS:    rd_mux = {pf_hits, cache_hits};
      default:              unmapped = 1'b1;
    endcase
  end

  // Answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access;
      pslverr <= access & (unmapped | bad_wr);
      prdata  <= (access && !pwrite && !unmapped) ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Mode registers
  // ----------------------------------------------------------------
  logic [5:0] new_cnt;
  assign new_cnt = pwdata[5:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl    <= sdc_pkg::CTRL_RST;
      segcnt  <= sdc_pkg::SEGCNT_RST;
      maxpf   <= sdc_pkg::MAXPF_RST;
      pfceil  <= sdc_pkg::PFCEIL_RST;
      cmd_lba <= 32'h0000_0000;
    end else if (wr_fire) begin
      if (paddr == sdc_pkg::OFS_CTRL) ctrl <= pwdata[7:0]; // [RULE_22]
      if (seg_wr && new_cnt >= 6'(sdc_pkg::MIN_SEGS) && new_cnt <= 6'(NSEG)) begin
        segcnt <= new_cnt; // [RULE_02]
      end
      if (paddr == sdc_pkg::OFS_PREFET) begin
        maxpf  <= pwdata[15:0];
        pfceil <= pwdata[31:16]; // Stored for read-back only [RULE_18]
      end
      if (paddr == sdc_pkg::OFS_CMDLBA) cmd_lba <= pwdata;
    end
  end

  // ----------------------------------------------------------------
  // Parallel lookup and sizing
  // ----------------------------------------------------------------
  logic [15:0]   seglen;
  logic          hit;
  logic [SW-1:0] hidx;
  logic [NSEG-1:0] ovl;
  logic [SW-1:0] didx;
  logic [31:0]   avail;
  logic [15:0]   take, chunk, cyl_room, pf_amt, seg_room;
  logic [31:0]   fetch_end;
  logic          pf_region;

  assign seglen = TOT_SECT / {10'h000, segcnt}; // [RULE_09]

  always_comb begin
    hit  = 1'b0;
    hidx = '0;
    ovl  = '0;
    didx = '0;
    for (int i = NSEG - 1; i >= 0; i--) begin
      if (seg_vld[i] && cur_lba >= seg_lba[i] && (cur_lba - seg_lba[i]) < {16'h0000, seg_cnt[i]}) begin
        hit  = 1'b1; // [RULE_23]
        hidx = SW'(i);
      end
      ovl[i] = seg_vld[i] && cur_lba < seg_lba[i] + {16'h0000, seg_cnt[i]}
               && seg_lba[i] < cur_lba + {16'h0000, rem};
      if (seg_dirty[i]) didx = SW'(i);
    end
  end

  assign avail     = seg_lba[hidx] + {16'h0000, seg_cnt[hidx]} - cur_lba;
  assign take      = (avail < {16'h0000, rem}) ? avail[15:0] : rem;
  assign chunk     = (rem < seglen) ? rem : seglen;
  assign pf_region = cur_lba >= seg_pfb[hidx];
  assign fetch_end = cur_lba + {16'h0000, chunk};
  assign seg_room  = seglen - chunk;

  always_comb begin
    cyl_room = 16'(CYL_SIZE - {7'h00, fetch_end[CYL_BITS-1:0]});
    if (fetch_end[CYL_BITS-1:0] == '0) cyl_room = 16'h0000;
    pf_amt = (maxpf < seg_room) ? maxpf : seg_room; // [RULE_18]
    if (!cyl_cross && cyl_room < pf_amt) pf_amt = cyl_room; // [RULE_19]
    if (!pf_on || chunk != rem) pf_amt = 16'h0000;
  end

  // Read caching off still accepts prefetched data
  logic use_hit;
  assign use_hit = hit && (!read_cache_disable || (!readahead_disable && pf_region)); // [RULE_04] [RULE_17]

  // Adaptive look-ahead decision for a new read
  logic contig, predict, next_pf;
  assign contig  = (cmd_lba == last_end);
  assign predict = cmd_lba >= last_end && (cmd_lba - last_end) <= {16'h0000, maxpf};
  assign next_pf = !readahead_disable && (interleave ? predict : contig); // [RULE_20] [RULE_21]

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= sdc_pkg::SDC_IDLE;
      op         <= sdc_pkg::SDC_OP_NONE;
      cur_lba    <= 32'h0000_0000;
      rem        <= 16'h0000;
      vic        <= '0;
      fl_idx     <= '0;
      fl_defer   <= 1'b0;
      mw_flush   <= 1'b0;
      wr_started <= 1'b0;
      pf_on      <= 1'b0;
      last_end   <= 32'h0000_0000;
      pf_amt_q   <= 16'h0000;
    end else begin
      unique case (state)
        sdc_pkg::SDC_IDLE: begin
          if (cmd_go) begin
            op         <= sdc_pkg::sdc_op_e'(pwdata[sdc_pkg::CMD_OP_LSB +: 2]);
            cur_lba    <= cmd_lba;
            rem        <= pwdata[15:0];
            wr_started <= 1'b0;
            fl_defer   <= 1'b1;
            if (pwdata[sdc_pkg::CMD_OP_LSB +: 2] == sdc_pkg::SDC_OP_READ) pf_on <= next_pf;
            state      <= sdc_pkg::SDC_FLUSH;
          end
        end
        sdc_pkg::SDC_FLUSH: begin
          if (any_dirty) begin
            fl_idx   <= didx; // [RULE_16]
            mw_flush <= 1'b1;
            state    <= sdc_pkg::SDC_MWAIT;
          end else if (op == sdc_pkg::SDC_OP_SYNC || op == sdc_pkg::SDC_OP_NONE) begin
            state <= sdc_pkg::SDC_DONE;
          end else begin
            fl_defer <= 1'b0;
            state    <= (op == sdc_pkg::SDC_OP_WRITE && wr_started && |rem) ? sdc_pkg::SDC_WRT : sdc_pkg::SDC_LOOK;
          end
        end
        sdc_pkg::SDC_LOOK: begin
          if (rem == 16'h0000) begin
            state <= sdc_pkg::SDC_DONE;
          end else if (op == sdc_pkg::SDC_OP_WRITE) begin
            wr_started <= 1'b1;
            state      <= sdc_pkg::SDC_WRT;
          end else begin
            state <= use_hit ? sdc_pkg::SDC_HIT : sdc_pkg::SDC_FETCH; // [RULE_05]
          end
        end
        sdc_pkg::SDC_HIT: begin
          cur_lba <= cur_lba + {16'h0000, take}; // [RULE_07]
          rem     <= rem - take;
          state   <= sdc_pkg::SDC_LOOK;
        end
        sdc_pkg::SDC_FETCH: begin
          pf_amt_q <= pf_amt;
          mw_flush <= 1'b0;
          state    <= sdc_pkg::SDC_MWAIT; // [RULE_08]
        end
        sdc_pkg::SDC_WRT: begin
          cur_lba <= fetch_end;
          rem     <= rem - chunk;
          vic     <= (32'(vic) + 1 >= 32'(segcnt)) ? '0 : vic + SW'(1);
          // Early completion only once the final chunk sits in the cache
          state   <= (write_back_enable && chunk == rem) ? sdc_pkg::SDC_DONE : sdc_pkg::SDC_FLUSH; // [RULE_15] [RULE_14]
        end
        sdc_pkg::SDC_MWAIT: begin
          if (med_ack) begin
            if (mw_flush) begin
              state <= sdc_pkg::SDC_FLUSH;
            end else begin
              cur_lba <= fetch_end;
              rem     <= rem - chunk;
              vic     <= (32'(vic) + 1 >= 32'(segcnt)) ? '0 : vic + SW'(1);
              state   <= (chunk == rem) ? sdc_pkg::SDC_DONE : sdc_pkg::SDC_LOOK;
            end
          end
        end
        sdc_pkg::SDC_DONE: begin
          if (op == sdc_pkg::SDC_OP_READ) last_end <= cur_lba;
          state <= sdc_pkg::SDC_IDLE;
        end
        default: state <= sdc_pkg::SDC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Segment table
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_vld   <= '0;
      seg_dirty <= '0;
      for (int i = 0; i < NSEG; i++) begin
        seg_lba[i] <= 32'h0000_0000;
        seg_cnt[i] <= 16'h0000;
        seg_pfb[i] <= 32'h0000_0000;
      end
    end else begin
      if (seg_wr) begin
        seg_vld <= '0; // New geometry voids every record [RULE_09]
      end
      if (state == sdc_pkg::SDC_LOOK && op == sdc_pkg::SDC_OP_WRITE && !wr_started && rem != 16'h0000) begin
        seg_vld <= seg_vld & ~ovl; // [RULE_13]
      end
      if (state == sdc_pkg::SDC_WRT) begin
        seg_vld[vic]   <= ~read_cache_disable; // [RULE_12]
        seg_dirty[vic] <= 1'b1;
        seg_lba[vic]   <= cur_lba; // [RULE_03]
        seg_cnt[vic]   <= chunk;
        seg_pfb[vic]   <= fetch_end;
      end
      if (state == sdc_pkg::SDC_MWAIT && med_ack) begin
        if (mw_flush) begin
          seg_dirty[fl_idx] <= 1'b0;
        end else begin
          seg_vld[vic] <= 1'b1;
          seg_lba[vic] <= cur_lba; // [RULE_03]
          seg_cnt[vic] <= chunk + pf_amt_q;
          seg_pfb[vic] <= fetch_end; // [RULE_17]
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Medium and host ports
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      med_req_valid <= 1'b0;
      med_req       <= '0;
    end else if (state == sdc_pkg::SDC_FLUSH && any_dirty) begin
      med_req_valid <= 1'b1;
      med_req       <= '{wr: 1'b1, lba: seg_lba[didx], cnt: seg_cnt[didx]};
    end else if (state == sdc_pkg::SDC_FETCH) begin
      med_req_valid <= 1'b1;
      med_req       <= '{wr: 1'b0, lba: cur_lba, cnt: chunk + pf_amt};
    end else if (med_ack) begin
      med_req_valid <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_xfer_valid <= 1'b0;
      host_xfer       <= '0;
    end else begin
      host_xfer_valid <= 1'b0;
      if (state == sdc_pkg::SDC_HIT) begin
        host_xfer_valid <= 1'b1;
        host_xfer       <= '{from_cache: 1'b1, paced: 1'b0, lba: cur_lba, cnt: take}; // [RULE_06]
      end else if (state == sdc_pkg::SDC_MWAIT && med_ack && !mw_flush) begin
        host_xfer_valid <= 1'b1;
        host_xfer       <= '{from_cache: 1'b0, paced: 1'b1, lba: cur_lba, cnt: chunk}; // [RULE_06]
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags and hit counters
  // ----------------------------------------------------------------
  logic set_defer, set_cmd_err, set_param;
  assign set_defer   = state == sdc_pkg::SDC_MWAIT && med_ack && med_err && mw_flush && fl_defer;
  assign set_cmd_err = state == sdc_pkg::SDC_MWAIT && med_ack && med_err && !(mw_flush && fl_defer);
  assign set_param   = wr_fire && paddr == sdc_pkg::OFS_SEGSIZE && reject_unchangeable_params; // [RULE_11]

  // Set beats a same-cycle software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deferred  <= 1'b0;
      param_err <= 1'b0;
      cmd_err   <= 1'b0;
      good      <= 1'b0;
    end else begin
      deferred  <= (deferred & ~(stat_wr & pwdata[sdc_pkg::ST_DEFERRED])) | set_defer; // [RULE_15]
      param_err <= (param_err & ~(stat_wr & pwdata[sdc_pkg::ST_PARAM_ERR])) | set_param;
      if (cmd_go) begin
        cmd_err <= 1'b0;
        good    <= 1'b0;
      end else begin
        cmd_err <= cmd_err | set_cmd_err;
        if (state == sdc_pkg::SDC_DONE) good <= ~cmd_err;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cache_hits <= 16'h0000;
      pf_hits    <= 16'h0000;
    end else if (state == sdc_pkg::SDC_HIT) begin
      if (pf_region) pf_hits <= pf_hits + 16'h0001; // [RULE_17]
      else cache_hits <= cache_hits + 16'h0001;
    end
  end

endmodule

`default_nettype wire

// *** test/sdc_cache_ctrl_sva.sv ***
// Port-level checker of the segmented disk cache controller
`timescale 1ns/1ps
`default_nettype none
module sdc_cache_ctrl_sva (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [7:0]              paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic                    med_ack,
  input wire logic                    med_err,
  input wire logic                    med_req_valid,
  input wire sdc_pkg::sdc_media_req_s med_req,
  input wire logic                    host_xfer_valid,
  input wire sdc_pkg::sdc_host_xfer_s host_xfer
);
  // ----------------------------------------------------------------
  // Register bus and medium handshakes
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data outside answer");
  a_segsize_zero: assert property (pready && !pwrite && paddr == sdc_pkg::OFS_SEGSIZE |-> prdata == 32'h0)
    else $error("segment size not zero");
  a_unmapped_err: assert property (pready && paddr > 8'h1C |-> pslverr)
    else $error("unmapped address accepted");
  a_req_hold: assert property (med_req_valid && !med_ack |=> med_req_valid && $stable(med_req))
    else $error("medium request changed");
  a_req_release: assert property (med_req_valid && med_ack |=> !med_req_valid)
    else $error("medium request kept");
  a_pace_kind: assert property (host_xfer_valid |-> host_xfer.paced == !host_xfer.from_cache)
    else $error("pacing wrong for run");
  a_miss_after_ack: assert property (host_xfer_valid && !host_xfer.from_cache |->
    $past(med_ack) && $past(med_req_valid))
    else $error("medium run before ack");
endmodule
bind sdc_cache_ctrl sdc_cache_ctrl_sva u_sdc_cache_ctrl_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .med_ack(med_ack), .med_err(med_err), .med_req_valid(med_req_valid),
  .med_req(med_req), .host_xfer_valid(host_xfer_valid), .host_xfer(host_xfer));
`default_nettype wire

// *** test/sdc_media_model.sv ***
// Disc medium model: acknowledges each request once, fast or slow
`timescale 1ns/1ps
`default_nettype none
module sdc_media_model (
  input wire logic  pclk,
  input wire logic  presetn,
  input wire logic  med_req_valid,
  input wire logic  err_en,
  input wire logic  slow,
  output logic      med_ack,
  output logic      med_err
);
  logic [3:0] wait_cnt;
  logic       done;
  logic       fire;
  assign fire = med_req_valid && !done && wait_cnt == (slow ? 4'h8 : 4'h1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 4'h0;
      done     <= 1'b0;
      med_ack  <= 1'b0;
    end else begin
      med_ack <= fire;
      done    <= med_req_valid && (done || fire);
      wait_cnt <= med_req_valid && !done ? wait_cnt + 4'h1 : 4'h0;
    end
  end
  // Error line toggles outside an ack so a stale value is never trusted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) med_err <= 1'b0;
    else med_err <= fire ? err_en : ~med_err;
  end
endmodule
`default_nettype wire

// *** test/test_sdc_cache_ctrl.sv ***
// Directed testbench of the segmented disk cache controller
`timescale 1ns/1ps
`default_nettype none
module test_sdc_cache_ctrl;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_en, slow, e_v;
  logic        med_ack, med_err, med_req_valid, host_xfer_valid;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [7:0]  tw [5];
  logic [7:0]  te [5];
  sdc_pkg::sdc_media_req_s med_req;
  sdc_pkg::sdc_host_xfer_s host_xfer;
  int          num_errors, check_count, i;
  initial begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end
  sdc_cache_ctrl u_sdc_cache_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .med_ack(med_ack), .med_err(med_err), .med_req_valid(med_req_valid), .med_req(med_req),
    .host_xfer_valid(host_xfer_valid), .host_xfer(host_xfer));
  sdc_media_model u_sdc_media_model (.pclk(pclk), .presetn(presetn), .med_req_valid(med_req_valid),
    .err_en(err_en), .slow(slow), .med_ack(med_ack), .med_err(med_err));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task finish_test;
    if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [49:0] g, x);
    check_count++;
    if (g !== x) begin
      num_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task apb(input logic w, logic [7:0] a, logic [31:0] d);
    int n;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd_v = prdata; e_v = pslverr; psel <= 1'b0; penable <= 1'b0;
    if (n == 40) begin num_errors++; finish_test(); end
    @(posedge pclk);
  endtask
  task rd(input logic [7:0] a, logic [31:0] x);
    apb(1'b0, a, 32'h0); chk(50'(rd_v), 50'(x));
  endtask
  // Waits for a medium request (sel 0) or a host run (sel 1)
  task wait_out(input logic sel, logic [49:0] x);
    int n;
    for (n = 0; n < 100; n++) begin
      @(posedge pclk);
      if ((sel ? host_xfer_valid : med_req_valid) === 1'b1) break;
    end
    if (n == 100) begin num_errors++; finish_test(); end
    chk(sel ? host_xfer : 50'(med_req), x);
  endtask
  task idle;
    int n;
    for (n = 0; n < 100; n++) begin
      apb(1'b0, sdc_pkg::OFS_STATUS, 32'h0);
      if (rd_v[sdc_pkg::ST_BUSY] === 1'b0) break;
    end
    if (n == 100) begin num_errors++; finish_test(); end
  endtask
  task cmd(input logic [31:0] lba, c);
    apb(1'b1, sdc_pkg::OFS_CMDLBA, lba); apb(1'b1, sdc_pkg::OFS_CMD, c);
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, err_en, slow, presetn} = 6'h0;
    paddr = 8'h0; pwdata = 32'h0; num_errors = 0; check_count = 0;
    tw = '{8'h00, 8'h21, 8'h20, 8'h01, 8'h10};
    te = '{8'h10, 8'h10, 8'h20, 8'h01, 8'h10};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1; @(posedge pclk);
    rd(sdc_pkg::OFS_CTRL, 32'h0); rd(sdc_pkg::OFS_PREFET, 32'hFFFF0100);
    rd(8'h20, 32'h0); chk(50'(e_v), 50'h1);
    for (i = 0; i < 5; i++) begin
      apb(1'b1, sdc_pkg::OFS_SEGCNT, {24'h0, tw[i]}); rd(sdc_pkg::OFS_SEGCNT, {24'h0, te[i]});
    end
    apb(1'b1, sdc_pkg::OFS_CTRL, 32'h2); apb(1'b1, sdc_pkg::OFS_SEGSIZE, 32'h40);
    rd(sdc_pkg::OFS_SEGSIZE, 32'h0);
    apb(1'b0, sdc_pkg::OFS_STATUS, 32'h0); chk(50'(rd_v[sdc_pkg::ST_PARAM_ERR]), 50'h1);
    apb(1'b1, sdc_pkg::OFS_CTRL, 32'h20); slow <= 1'b1;
    cmd(32'h64, 32'h00010004); wait_out(1'b0, {1'b0, 32'h64, 16'h4});
    apb(1'b1, sdc_pkg::OFS_CMD, 32'h00010004); chk(50'(e_v), 50'h1);
    wait_out(1'b1, {1'b0, 1'b1, 32'h64, 16'h4}); idle(); slow <= 1'b0;
    cmd(32'h64, 32'h00010004); wait_out(1'b1, {1'b1, 1'b0, 32'h64, 16'h4}); idle();
    rd(sdc_pkg::OFS_HITS, 32'h1);
    cmd(32'h66, 32'h00010006); wait_out(1'b1, {1'b1, 1'b0, 32'h66, 16'h2});
    wait_out(1'b0, {1'b0, 32'h68, 16'h4}); wait_out(1'b1, {1'b0, 1'b1, 32'h68, 16'h4}); idle();
    apb(1'b1, sdc_pkg::OFS_CTRL, 32'h21);
    cmd(32'h64, 32'h00010004); wait_out(1'b0, {1'b0, 32'h64, 16'h4}); idle();
    apb(1'b1, sdc_pkg::OFS_CTRL, 32'h1); apb(1'b1, sdc_pkg::OFS_PREFET, 32'h00010008);
    cmd(32'hC8, 32'h00010004); wait_out(1'b0, {1'b0, 32'hC8, 16'h4}); idle();
    cmd(32'hCC, 32'h00010004); wait_out(1'b0, {1'b0, 32'hCC, 16'hC}); idle();
    apb(1'b1, sdc_pkg::OFS_CTRL, 32'h20); cmd(32'h190, 32'h00020002);
    wait_out(1'b0, {1'b1, 32'h190, 16'h2}); idle();
    apb(1'b1, sdc_pkg::OFS_CTRL, 32'h24);
    cmd(32'h12C, 32'h00020002); idle(); chk(50'({rd_v[6], rd_v[3], rd_v[1]}), 50'h5);
    err_en <= 1'b1;
    apb(1'b1, sdc_pkg::OFS_CMD, 32'h00030000); wait_out(1'b0, {1'b1, 32'h12C, 16'h2});
    idle(); chk(50'({rd_v[6], rd_v[3]}), 50'h1);
    finish_test();
  end
endmodule
`default_nettype wire
